// ===== logic/sfp_map.vh
// Constants for the serial flash programming port: command codes,
// address map, frame lengths and erase timing.
// Assumes a 100 MHz system clock and an externally driven link clock.
`ifndef SFP_MAP_VH
`define SFP_MAP_VH
`define SFP_CMD_LAST      4'h5
`define SFP_FRAME_LAST    4'hf
`define SFP_PAY_FIRST     4'h1
`define SFP_PAY_LAST      4'he
`define SFP_RD_START      4'h1
`define SFP_RD_END        4'hf
`define SFP_C_LOAD_CFG    5'h00
`define SFP_C_LOAD_PROG   5'h02
`define SFP_C_READ_PROG   5'h04
`define SFP_C_INC_ADDR    5'h06
`define SFP_C_BEGIN_ERASE 5'h08
`define SFP_C_BEGIN_PROG  5'h18
`define SFP_C_BULK_PROG   5'h09
`define SFP_C_BULK_DATA   5'h0b
`define SFP_C_CHIP_ERASE  5'h1f
`define SFP_C_LOAD_DATA   5'h03
`define SFP_C_READ_DATA   5'h05
`define SFP_C_END_PROG    5'h17
`define SFP_PC_CFG_BASE   14'h2000
`define SFP_PC_CFG_AVAIL  14'h2008
`define SFP_CFG_DEVID     5'h06
`define SFP_CFG_WORD1     5'h07
`define SFP_CFG_WORD2     5'h08
`define SFP_CFG_ID_LAST   5'h05
`define SFP_PROT_PROG_BIT 13
`define SFP_PROT_DATA_BIT 8
`define SFP_ERASED_WORD   14'h3fff
`define SFP_ERASED_BYTE   8'hff
`define SFP_CHIP_ERASE_MS 8
`define SFP_CLK_KHZ       100000
`define SFP_CHIP_ERASE_CYC (`SFP_CHIP_ERASE_MS * `SFP_CLK_KHZ)
`endif

// ===== logic/sfp_port.v
// Serial flash programming port with its program, config and data arrays.
// Assumes the link clock and data pin are asynchronous to clk_i and that
// the external wire level is resolved from the output enable outside.
`timescale 1ns/1ps
`include "sfp_map.vh"

module sfp_port #(
    parameter integer PROG_WORDS        = 4096,
    parameter integer DATA_BYTES        = 256,
    parameter integer CHIP_ERASE_CYCLES = `SFP_CHIP_ERASE_CYC,
    parameter [13:0]  DEV_ID_WORD       = 14'h0155
) (
    // System
    input  wire        clk_i,
    input  wire        arst_n_i,
    // Programming pins
    input  wire        mode_select_pin_i,
    input  wire        prog_clock_pin_i,
    input  wire        prog_data_pin_i,
    output reg         prog_data_pin_o,
    output reg         prog_data_pin_oe_o,
    // Status
    output reg         busy_o,
    output reg         chip_erase_busy_o
);

    // DEV_ID_WORD default is arbitrary
    localparam [1:0]  ST_CMD  = 2'd0;
    localparam [1:0]  ST_LOAD = 2'd1;
    localparam [1:0]  ST_READ = 2'd2;
    localparam integer CE_LAST_I = CHIP_ERASE_CYCLES - 1;
    localparam [19:0]  CE_LAST   = CE_LAST_I[19:0]; // Counter is 20 bits wide

    reg [1:0]  clk_s;
    reg [1:0]  dat_s;
    reg [1:0]  mode_s;
    reg        clk_d;
    reg [1:0]  state;
    reg [3:0]  bit_cnt;
    reg [3:0]  rise_cnt;
    reg [5:0]  cmd_sh;
    reg [13:0] rx_sh;
    reg [13:0] tx_sh;
    reg [13:0] pc;
    reg        mem_is_data;
    reg        bulk_prog_arm;
    reg        bulk_data_arm;
    reg [19:0] chip_cnt;
    reg        prot_prog;
    reg        prot_data;
    reg [13:0] wr_latch [0:3];
    reg [7:0]  data_latch;
    reg [13:0] prog_mem [0:PROG_WORDS-1];
    reg [13:0] cfg_mem  [0:31];
    reg [7:0]  data_mem [0:DATA_BYTES-1];
    integer    i;
    integer    j;

    // Two-stage synchronisers for all pins
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_s  <= 2'h0;
            dat_s  <= 2'h0;
            mode_s <= 2'h0;
            clk_d  <= 1'b0;
        end else begin
            clk_s  <= {clk_s[0], prog_clock_pin_i};
            dat_s  <= {dat_s[0], prog_data_pin_i};
            mode_s <= {mode_s[0], mode_select_pin_i};
            clk_d  <= clk_s[1];
        end
    end

    // Link clock edges and synchronised levels
    wire fall    = clk_d & ~clk_s[1];
    wire rise    = ~clk_d & clk_s[1];
    wire din     = dat_s[1];
    wire in_mode = mode_s[1];

    // Command word after the current bit, low five bits decode
    wire [5:0] next_cmd = {din, cmd_sh[5:1]};
    wire [4:0] code     = next_cmd[4:0];
    wire       cmd_fire = in_mode & (state == ST_CMD) & fall &
                          (bit_cnt == `SFP_CMD_LAST);

    // Address decode
    wire        in_cfg   = pc[13];
    wire        cfg_phys = in_cfg & (pc[12:5] == 8'h00);
    wire        cfg_avl  = in_cfg & (pc <= `SFP_PC_CFG_AVAIL);
    wire [4:0]  cidx     = pc[4:0];
    wire [11:0] pidx     = pc[11:0];
    wire [7:0]  didx     = pc[7:0];
    wire [1:0]  lidx     = pc[1:0];

    // Config read with live protection bits and fixed device id
    reg [13:0] cfg_rd;
    always @* begin
        if (cidx == `SFP_CFG_DEVID) begin
            cfg_rd = DEV_ID_WORD;
        end else if (cidx == `SFP_CFG_WORD1) begin
            cfg_rd = cfg_mem[cidx];
            cfg_rd[`SFP_PROT_PROG_BIT] = prot_prog;
            cfg_rd[`SFP_PROT_DATA_BIT] = prot_data;
        end else begin
            cfg_rd = cfg_mem[cidx];
        end
    end

    // Protected locations read as zeros, config stays readable
    wire [13:0] prog_rd = cfg_phys ? cfg_rd :
                          (prot_prog ? prog_mem[pidx] : 14'h0000);
    wire [7:0]  data_rd = prot_data ? data_mem[didx] : 8'h00;

    // Memory arrays act on decoded commands
    always @(posedge clk_i) begin
        if (cmd_fire) begin
            case (code)
                `SFP_C_BEGIN_ERASE: begin
                    if (bulk_prog_arm) begin
                        for (i = 0; i < PROG_WORDS; i = i + 1) begin
                            prog_mem[i] <= `SFP_ERASED_WORD;
                        end
                        if (cfg_avl) begin
                            for (i = 0; i <= `SFP_CFG_ID_LAST; i = i + 1) begin
                                cfg_mem[i] <= `SFP_ERASED_WORD;
                            end
                        end
                    end else if (bulk_data_arm) begin
                        for (i = 0; i < DATA_BYTES; i = i + 1) begin
                            data_mem[i] <= `SFP_ERASED_BYTE;
                        end
                    end else if (mem_is_data) begin
                        if (prot_data) begin
                            data_mem[didx] <= `SFP_ERASED_BYTE;
                        end
                    end else if (!in_cfg && prot_prog) begin
                        for (i = 0; i < 32; i = i + 1) begin
                            prog_mem[{pidx[11:5], i[4:0]}] <= `SFP_ERASED_WORD;
                        end
                    end
                end
                `SFP_C_BEGIN_PROG: begin
                    if (mem_is_data) begin
                        if (prot_data) begin
                            data_mem[didx] <= data_latch;
                        end
                    end else if (!in_cfg) begin
                        if (prot_prog) begin
                            for (i = 0; i < 4; i = i + 1) begin
                                prog_mem[{pidx[11:2], i[1:0]}] <= wr_latch[i];
                            end
                        end
                    end else if (cfg_avl && cidx != `SFP_CFG_DEVID) begin
                        cfg_mem[cidx] <= wr_latch[lidx];
                    end
                end
                `SFP_C_CHIP_ERASE: begin
                    for (i = 0; i < PROG_WORDS; i = i + 1) begin
                        prog_mem[i] <= `SFP_ERASED_WORD;
                    end
                    for (i = 0; i < DATA_BYTES; i = i + 1) begin
                        data_mem[i] <= `SFP_ERASED_BYTE;
                    end
                    if (pc == `SFP_PC_CFG_BASE) begin
                        for (i = 0; i < 32; i = i + 1) begin
                            if (i < 6 || i > 8) begin
                                cfg_mem[i] <= `SFP_ERASED_WORD;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Link sequencer, address counter and write latches
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state              <= ST_CMD;
            bit_cnt            <= 4'h0;
            rise_cnt           <= 4'h0;
            cmd_sh             <= 6'h00;
            rx_sh              <= 14'h0000;
            tx_sh              <= 14'h0000;
            pc                 <= 14'h0000;
            mem_is_data        <= 1'b0;
            bulk_prog_arm      <= 1'b0;
            bulk_data_arm      <= 1'b0;
            busy_o             <= 1'b0;
            prog_data_pin_o    <= 1'b0;
            prog_data_pin_oe_o <= 1'b0;
            data_latch         <= `SFP_ERASED_BYTE;
            for (j = 0; j < 4; j = j + 1) begin
                wr_latch[j] <= `SFP_ERASED_WORD;
            end
        end else if (!in_mode) begin
            // Leaving program mode is the only way back to user space
            state              <= ST_CMD;
            bit_cnt            <= 4'h0;
            pc                 <= 14'h0000;
            bulk_prog_arm      <= 1'b0;
            bulk_data_arm      <= 1'b0;
            busy_o             <= 1'b0;
            prog_data_pin_o    <= 1'b0;
            prog_data_pin_oe_o <= 1'b0;
        end else begin
            case (state)
                ST_CMD: begin
                    if (fall) begin
                        cmd_sh  <= next_cmd;
                        bit_cnt <= (bit_cnt == `SFP_CMD_LAST) ? 4'h0 : bit_cnt + 4'h1;
                    end
                    if (cmd_fire) begin
                        rise_cnt <= 4'h0;
                        case (code)
                            `SFP_C_LOAD_CFG: begin
                                pc          <= `SFP_PC_CFG_BASE;
                                mem_is_data <= 1'b0;
                                state       <= ST_LOAD;
                            end
                            `SFP_C_LOAD_PROG: begin
                                mem_is_data <= 1'b0;
                                state       <= ST_LOAD;
                            end
                            `SFP_C_LOAD_DATA: begin
                                mem_is_data <= 1'b1;
                                state       <= ST_LOAD;
                            end
                            `SFP_C_READ_PROG: begin
                                mem_is_data <= 1'b0;
                                tx_sh       <= prog_rd;
                                state       <= ST_READ;
                            end
                            `SFP_C_READ_DATA: begin
                                mem_is_data <= 1'b1;
                                tx_sh       <= {6'h00, data_rd};
                                state       <= ST_READ;
                            end
                            `SFP_C_INC_ADDR: begin
                                // Config space keeps its top bit set
                                if (in_cfg) begin
                                    pc <= {1'b1, pc[12:0] + 13'h0001};
                                end else begin
                                    pc <= pc + 14'h0001;
                                end
                            end
                            `SFP_C_BEGIN_ERASE: begin
                                busy_o        <= 1'b1;
                                bulk_prog_arm <= 1'b0;
                                bulk_data_arm <= 1'b0;
                            end
                            `SFP_C_BEGIN_PROG: begin
                                busy_o <= 1'b1;
                            end
                            `SFP_C_BULK_PROG: begin
                                bulk_prog_arm <= prot_prog;
                            end
                            `SFP_C_BULK_DATA: begin
                                bulk_data_arm <= prot_data;
                            end
                            `SFP_C_END_PROG: begin
                                busy_o     <= 1'b0;
                                data_latch <= `SFP_ERASED_BYTE;
                                for (j = 0; j < 4; j = j + 1) begin
                                    wr_latch[j] <= `SFP_ERASED_WORD;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_LOAD: begin
                    if (fall) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt >= `SFP_PAY_FIRST && bit_cnt <= `SFP_PAY_LAST) begin
                            rx_sh <= {din, rx_sh[13:1]};
                        end
                        if (bit_cnt == `SFP_FRAME_LAST) begin
                            state   <= ST_CMD;
                            bit_cnt <= 4'h0;
                            if (mem_is_data) begin
                                data_latch <= rx_sh[7:0];
                            end else begin
                                wr_latch[lidx] <= rx_sh;
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (rise) begin
                        rise_cnt <= rise_cnt + 4'h1;
                        if (rise_cnt >= `SFP_RD_START && rise_cnt < `SFP_RD_END) begin
                            prog_data_pin_oe_o <= 1'b1;
                            prog_data_pin_o    <= tx_sh[0];
                            tx_sh              <= {1'b0, tx_sh[13:1]};
                        end
                        if (rise_cnt == `SFP_RD_END) begin
                            prog_data_pin_oe_o <= 1'b0;
                            prog_data_pin_o    <= 1'b0;
                        end
                    end
                    if (fall) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `SFP_FRAME_LAST) begin
                            state              <= ST_CMD;
                            bit_cnt            <= 4'h0;
                            prog_data_pin_oe_o <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_CMD;
                end
            endcase
        end
    end

    // Self-timed chip erase and protection bits, set unprotected by reset
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chip_cnt          <= 20'h00000;
            chip_erase_busy_o <= 1'b0;
            prot_prog         <= 1'b1;
            prot_data         <= 1'b1;
        end else if (chip_erase_busy_o) begin
            chip_cnt <= chip_cnt + 20'h00001;
            if (chip_cnt == CE_LAST) begin
                chip_erase_busy_o <= 1'b0;
                prot_prog         <= 1'b1;
                prot_data         <= 1'b1;
            end
        end else if (cmd_fire && code == `SFP_C_CHIP_ERASE) begin
            chip_erase_busy_o <= 1'b1;
            chip_cnt          <= 20'h00000;
        end else if (cmd_fire && code == `SFP_C_BEGIN_PROG && !mem_is_data &&
                     pc == (`SFP_PC_CFG_BASE | {9'h000, `SFP_CFG_WORD1})) begin
            prot_prog <= wr_latch[lidx][`SFP_PROT_PROG_BIT];
            prot_data <= wr_latch[lidx][`SFP_PROT_DATA_BIT];
        end
    end

endmodule // sfp_port

// ===== sim/sfp_port_asserts.sv
// Pin-level checks for the serial programming port.
// Assumes binding onto sfp_port; sees only its ports.
`timescale 1ns/1ps

module sfp_port_asserts #(
    parameter integer CHIP_ERASE_CYCLES = 50
) (
    // System
    input wire clk_i,
    input wire arst_n_i,
    // Programming pins and status
    input wire mode_select_pin_i,
    input wire prog_clock_pin_i,
    input wire prog_data_pin_i,
    input wire prog_data_pin_o,
    input wire prog_data_pin_oe_o,
    input wire busy_o,
    input wire chip_erase_busy_o
);
    localparam integer CE_MAX = CHIP_ERASE_CYCLES + 4;
    localparam integer CE_MIN = CHIP_ERASE_CYCLES - 4;
    reg        clk_seen;
    reg [4:0]  rise_cnt;
    reg [31:0] ce_cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // Link rises while driving, and chip erase length
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_seen <= 1'b0;
            rise_cnt <= 5'h00;
            ce_cnt   <= 32'h0;
        end else begin
            clk_seen <= prog_clock_pin_i;
            if (!prog_data_pin_oe_o)
                rise_cnt <= 5'h00;
            else if (prog_clock_pin_i && !clk_seen)
                rise_cnt <= rise_cnt + 5'h01;
            ce_cnt <= chip_erase_busy_o ? ce_cnt + 32'h1 : 32'h0;
        end
    end

    oe_mode_a: assert property (!mode_select_pin_i [*4] |-> !prog_data_pin_oe_o)
        else $error("data pin driven outside program mode");
    busy_mode_a: assert property (!mode_select_pin_i [*4] |-> !busy_o)
        else $error("busy held outside program mode");
    oe_rise_a: assert property ($rose(prog_data_pin_oe_o) |-> prog_clock_pin_i)
        else $error("drive began away from a rising link edge");
    oe_fall_a: assert property ($fell(prog_data_pin_oe_o) && mode_select_pin_i
        |-> prog_clock_pin_i)
        else $error("release away from a rising link edge");
    bit_change_a: assert property (prog_data_pin_oe_o && $past(prog_data_pin_oe_o)
        && $changed(prog_data_pin_o) |-> prog_clock_pin_i)
        else $error("read bit changed while link clock low");
    oe_span_a: assert property ($fell(prog_data_pin_oe_o) && mode_select_pin_i
        |-> rise_cnt == 5'd14)
        else $error("read drive did not span rises two to sixteen");
    ce_stop_a: assert property (chip_erase_busy_o |-> ce_cnt <= CE_MAX)
        else $error("chip erase ran too long");
    ce_full_a: assert property ($fell(chip_erase_busy_o) && mode_select_pin_i
        |-> ce_cnt >= CE_MIN)
        else $error("chip erase ended early");
endmodule // sfp_port_asserts

bind sfp_port sfp_port_asserts #(
    .CHIP_ERASE_CYCLES (CHIP_ERASE_CYCLES)
) i_chk (
    .clk_i (clk_i), .arst_n_i (arst_n_i),
    .mode_select_pin_i (mode_select_pin_i), .prog_clock_pin_i (prog_clock_pin_i),
    .prog_data_pin_i (prog_data_pin_i), .prog_data_pin_o (prog_data_pin_o),
    .prog_data_pin_oe_o (prog_data_pin_oe_o), .busy_o (busy_o),
    .chip_erase_busy_o (chip_erase_busy_o)
);

// ===== sim/sfp_prog_model.sv
// External programmer model: link clock, data drive and read capture.
// Assumes the bench resolves the data wire from both enables.
`timescale 1ns/1ps

module sfp_prog_model (
    // Link pins
    output reg  clk_o,
    output reg  data_o,
    output reg  data_oe_o,
    input  wire data_i
);
    // Tasks start on a bench clock edge; the lead keeps link edges
    // 2.5 ns away from every system clock edge, period stays 125 ns
    localparam real LEAD = 2.5;
    localparam real HIGH = 60.0;
    localparam real LOW  = 65.0;
    localparam real GAP  = 997.5;
    reg [13:0] rd_word;
    event      rd_done;
    integer    i;

    // Clock stands low between frames; line held low
    initial begin
        clk_o = 1'b0;
        data_o = 1'b0;
        data_oe_o = 1'b1;
    end

    // One cycle: change on the rise, device samples on the fall
    task cyc(input b);
        begin
            clk_o = 1'b1;
            data_o = b;
            #HIGH;
            clk_o = 1'b0;
            #LOW;
        end
    endtask

    // Six command bits, LSb first, then decode gap
    task cmd(input [5:0] c);
        begin
            #LEAD;
            for (i = 0; i < 6; i = i + 1) cyc(c[i]);
            data_o = 1'b0;
            #GAP;
        end
    endtask

    // Load frame: zero start, 14 bits LSb first, zero stop
    task frame_out(input [13:0] w);
        begin
            #LEAD;
            cyc(1'b0);
            for (i = 0; i < 14; i = i + 1) cyc(w[i]);
            cyc(1'b0);
            #GAP;
        end
    endtask

    // Read frame: line released, each bit taken just before the fall
    task frame_in;
        begin
            data_oe_o = 1'b0;
            #LEAD;
            for (i = 0; i < 16; i = i + 1) begin
                clk_o = 1'b1;
                #HIGH;
                if (i >= 1 && i <= 14) rd_word[i-1] = data_i;
                clk_o = 1'b0;
                #LOW;
            end
            data_oe_o = 1'b1;
            -> rd_done;
            #GAP;
        end
    endtask
endmodule // sfp_prog_model

// ===== sim/test_sfp_port.sv
// Self-checking bench for the serial programming port.
// Assumes sfp_port, the checker and the programmer model are compiled.
`timescale 1ns/1ps

module test_sfp_port;
    localparam integer CE_CYC = 400;
    localparam integer LIMIT  = 40000;
    localparam [13:0]  DEV_ID = 14'h0a5a; // Arbitrary value
    reg         clk_i;
    reg         arst_n_i;
    reg         mode_sel;
    reg         float_bit;
    wire        pin;
    wire        link_clk;
    wire        prog_d;
    wire        prog_oe;
    wire        dut_d;
    wire        dut_oe;
    wire        busy;
    wire        ce_busy;
    reg  [31:0] rnd;
    reg  [13:0] exp_q[$];
    reg  [13:0] w;
    integer     err_count;
    integer     samples_checked;
    integer     cycles = 0;
    integer     k;

    // Wire level; a released line shows a toggling pattern
    assign pin = dut_oe ? dut_d : (prog_oe ? prog_d : float_bit);
    always #5 clk_i = ~clk_i;
    always @(negedge clk_i) float_bit <= ~float_bit;

    sfp_port #(.CHIP_ERASE_CYCLES (CE_CYC), .DEV_ID_WORD (DEV_ID)) i_dut (
        .clk_i (clk_i), .arst_n_i (arst_n_i), .mode_select_pin_i (mode_sel),
        .prog_clock_pin_i (link_clk), .prog_data_pin_i (pin), .prog_data_pin_o (dut_d),
        .prog_data_pin_oe_o (dut_oe), .busy_o (busy), .chip_erase_busy_o (ce_busy));
    sfp_prog_model i_prog (.clk_o (link_clk), .data_o (prog_d), .data_oe_o (prog_oe),
        .data_i (pin));

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    task check(input [13:0] seen, input [13:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
            end
        end
    endtask

    task test_done;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // Command with a random sixth bit
    task send(input [4:0] c);
        begin
            rnd = xs(rnd);
            i_prog.cmd({rnd[0], c});
        end
    endtask

    task ld(input [4:0] c, input [13:0] d);
        begin
            send(c);
            i_prog.frame_out(d);
        end
    endtask

    task rd(input [4:0] c, input [13:0] e);
        begin
            exp_q.push_back(e);
            send(c);
            i_prog.frame_in;
        end
    endtask

    // Begin programming, then end programming
    task prog;
        begin
            send(5'h18);
            check({13'h0, busy}, 14'h0001);
            send(5'h17);
            check({13'h0, busy}, 14'h0000);
        end
    endtask

    task wait_ce(input want);
        begin
            k = 0;
            while (ce_busy !== want && k < 600) begin
                @(negedge clk_i);
                k = k + 1;
            end
            check({13'h0, ce_busy}, {13'h0, want});
        end
    endtask

    task erase_all;
        begin
            send(5'h1f);
            wait_ce(1'b1);
            wait_ce(1'b0);
            send(5'h17);
        end
    endtask

    // Read results compared against the oldest note
    always @(i_prog.rd_done) check(i_prog.rd_word, exp_q.pop_front());

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: timeout", $time);
            test_done;
        end
    end

    initial begin
        clk_i = 1'b0;
        arst_n_i = 1'b0;
        mode_sel = 1'b0;
        float_bit = 1'b0;
        rnd = 32'd42;
        err_count = 0;
        samples_checked = 0;
        repeat (4) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        mode_sel = 1'b1;
        repeat (10) @(negedge clk_i);
        erase_all;
        rd(5'h04, 14'h3fff);
        $display("test chip erase done");
        rnd = xs(rnd);
        w = rnd[13:0];
        ld(5'h02, w);
        prog;
        rd(5'h04, w);
        send(5'h06);
        rd(5'h04, 14'h3fff);
        $display("test program word done");
        rnd = xs(rnd);
        w = rnd[13:0];
        ld(5'h03, w);
        prog;
        rd(5'h05, {6'h00, w[7:0]});
        send(5'h08);
        send(5'h17);
        rd(5'h05, 14'h00ff);
        $display("test data byte done");
        ld(5'h00, 14'h3ff5);
        prog;
        rd(5'h04, 14'h3ff5);
        for (k = 0; k < 6; k = k + 1) send(5'h06);
        rd(5'h04, DEV_ID);
        send(5'h06);
        ld(5'h02, 14'h1eff);
        prog;
        rd(5'h04, 14'h1eff);
        $display("test configuration done");
        mode_sel = 1'b0;
        repeat (10) @(negedge clk_i);
        mode_sel = 1'b1;
        repeat (10) @(negedge clk_i);
        rd(5'h04, 14'h0000);
        rd(5'h05, 14'h0000);
        send(5'h09);
        send(5'h08);
        send(5'h17);
        rd(5'h05, 14'h0000);
        erase_all;
        rd(5'h04, 14'h3fff);
        rd(5'h05, 14'h00ff);
        $display("test protection done");
        for (k = 0; k < 2; k = k + 1) begin
            ld(k ? 5'h03 : 5'h02, 14'h0000);
            prog;
            rd(k ? 5'h05 : 5'h04, 14'h0000);
            send(k ? 5'h0b : 5'h09);
            send(5'h08);
            send(5'h17);
            rd(k ? 5'h05 : 5'h04, k ? 14'h00ff : 14'h3fff);
        end
        $display("test bulk erase done");
        test_done;
    end
endmodule // test_sfp_port
